/* File: hdl/tss_dev.sv */
// What this block does
// - Start a conversion at least every 125 ms.
// - Temperature read returns newest completed conversion.
// - Conversion mid-read never changes shifted bytes.
// - Pointer resets to capability register.
// - Event off, comparator, active low, zero limits.
// - Capability register resets to 00F7h.
// - Bus control register resets to 21h.
// - Long SCL low returns slave to idle.
// - Timeout on after reset; bit 7 disables.
// - Device never drives SCL.
// - Host clocks no slower than 10 kHz.
// - Alert address acknowledged only interrupt, polarity zero.
// - Arbitrate on alert answer; winner clears event.
// - Alert answer off after reset; clearing bit 0 enables.
// - Host must remedy persistent event conditions.
// - Pointer holds last written value.
// - Write is address, pointer, then two data.
// - Read uses latched pointer or repeated start.
// - Data shifted most significant bit first.
// - Final acknowledge or not-acknowledge both accepted.
// - Registers are read-only or read-write by type.
// - Threshold registers unlocked after reset.
// - Config selects event polarity, enable, status, clear.
`timescale 1ns/10ps
module tss_dev
	import tss_pkg::*;
#(
	parameter int CONV_P = tss_pkg::CONV_CYC,
	parameter int TOUT_P = tss_pkg::TOUT_CYC
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	tss_if.dev                     bus,
	input  wire logic [2:0]        addr_pins,
	input  wire logic [TEMP_W-1:0] conv_data,
	input  wire logic              conv_valid,
	output logic                   conv_start
);
	import tss_pkg::*;

	localparam int CW = $clog2(CONV_P + 1);
	localparam int TW = $clog2(TOUT_P + 1);

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_TACK
	} tss_dst_t;

	typedef struct packed {
		tss_dst_t          st;
		logic [7:0]        sh;
		logic [3:0]        bc;
		logic              rw;
		logic              ara;
		logic              nack;
		logic [1:0]        bi;
		logic              tb;
		logic [7:0]        ptr;
		logic [7:0]        wmsb;
		logic [15:0]       rdat;
		logic [15:0]       cfg;
		logic [15:0]       upper;
		logic [15:0]       lower;
		logic [15:0]       crit;
		logic [15:0]       busc;
		logic [TEMP_W-1:0] temp;
		logic              ev;
		logic              alarm_p;
		logic [CW-1:0]     ccnt;
		logic [TW-1:0]     tcnt;
		logic              conv_start;
		logic              sda_oe_n;
		logic              evt_oe_n;
	} tss_dev_state_t;

	// Power-up values of every register.
	localparam tss_dev_state_t RST = '{
		st: ST_IDLE, ptr: PTR_RST, cfg: CFG_RST, upper: LIM_RST,
		lower: LIM_RST, crit: LIM_RST, busc: BUSC_RST,
		sda_oe_n: 1'b1, evt_oe_n: 1'b1, default: '0
	};

	tss_dev_state_t q;
	tss_dev_state_t d;
	logic [4:0]     s_lvl;
	logic [4:0]     s_prv;
	logic           scl_r;
	logic           scl_f;
	logic           start;
	logic           stop;
	logic           tout;
	logic [6:0]     own;
	logic           above;
	logic           below;
	logic           crit_f;
	logic           asserted;
	logic           ara_ok;
	logic           ev_clr;
	logic [15:0]    rd;

	// ==========================================================
	// Pin sampling
	// ==========================================================
	tss_sync #(.W(5)) u_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.din  ({addr_pins, bus.scl, bus.sda}),
		.lvl  (s_lvl),
		.prv  (s_prv)
	);

	// Bus conditions from the synchronised SCL (bit 1) and SDA (bit 0).
	assign scl_r = s_lvl[1] & ~s_prv[1];
	assign scl_f = ~s_lvl[1] & s_prv[1];
	assign start = s_lvl[1] & s_prv[1] & s_prv[0] & ~s_lvl[0];
	assign stop  = s_lvl[1] & s_prv[1] & ~s_prv[0] & s_lvl[0];
	assign own   = {TS_TYPE, s_lvl[4:2]};

	// Readback of the register selected by the pointer.
	function automatic logic [15:0] reg_read(input logic [7:0] p);
		case (p)
			PTR_CAP:   reg_read = CAP_RST;
			PTR_CFG:   reg_read = q.cfg;
			PTR_UPPER: reg_read = q.upper;
			PTR_LOWER: reg_read = q.lower;
			PTR_CRIT:  reg_read = q.crit;
			PTR_TEMP:  reg_read = {crit_f, above, below, q.temp};
			PTR_BUSC:  reg_read = q.busc;
			default:   reg_read = '0;
		endcase
	endfunction : reg_read

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		d = q;
		ev_clr = 1'b0;
		d.conv_start = 1'b0;

		// Free-running conversion timer.
		if (q.ccnt == CW'(CONV_P - 1)) begin
			d.ccnt = '0;
			d.conv_start = 1'b1;
		end else begin
			d.ccnt = q.ccnt + 1'b1;
		end
		if (conv_valid) begin
			d.temp = conv_data;
		end

		// Window and critical comparison on signed temperatures.
		above = $signed(q.temp) > $signed(q.upper[TEMP_W-1:0]);
		below = $signed(q.temp) < $signed(q.lower[TEMP_W-1:0]);
		crit_f = $signed(q.temp) >= $signed(q.crit[TEMP_W-1:0]);
		asserted = q.cfg[CFG_MODE] ? (q.ev | crit_f)
			: (above | below | crit_f);
		ara_ok = q.cfg[CFG_MODE] & ~q.cfg[CFG_POL]
			& ~q.busc[BUSC_ARA_OFF] & asserted;
		// Readback is taken only once the flags that it carries are settled.
		rd = reg_read(q.ptr);

		// SCL low watchdog; it sleeps while idle or disabled.
		if (q.st == ST_IDLE || s_lvl[1] || q.busc[BUSC_TOUT_OFF]) begin
			d.tcnt = '0;
		end else if (q.tcnt != TW'(TOUT_P)) begin
			d.tcnt = q.tcnt + 1'b1;
		end
		tout = (q.tcnt == TW'(TOUT_P));

		// Serial engine; SCL is only ever sampled, never driven.
		if (stop || tout) begin
			d.st = ST_IDLE;
			d.sda_oe_n = 1'b1;
		end else if (start) begin
			d.st = ST_ADDR;
			d.bc = '0;
			d.sda_oe_n = 1'b1;
		end else begin
			case (q.st)
				ST_ADDR: begin
					if (scl_r) begin
						d.sh = {q.sh[6:0], s_lvl[0]};
						d.bc = q.bc + 1'b1;
					end else if (scl_f && q.bc == ACK_SLOT) begin
						d.rw = q.sh[0];
						d.st = ST_AACK;
						d.sda_oe_n = 1'b0;
						d.ara = 1'b0;
						if (q.sh[7:1] == ARA_ADDR && q.sh[0] && ara_ok) begin
							d.ara = 1'b1;
						end else if (q.sh[7:1] != own) begin
							d.st = ST_IDLE;
							d.sda_oe_n = 1'b1;
						end
					end
				end
				ST_AACK: begin
					if (scl_f) begin
						d.bc = '0;
						d.bi = '0;
						d.tb = 1'b0;
						d.nack = 1'b0;
						if (q.rw) begin
							// Snapshot now; later conversions wait.
							d.rdat = rd;
							d.sh = q.ara ? {own, 1'b0} : rd[15:8];
							d.sda_oe_n = q.ara ? own[6] : rd[15];
							d.st = ST_TX;
						end else begin
							d.sda_oe_n = 1'b1;
							d.st = ST_RX;
						end
					end
				end
				ST_RX: begin
					if (scl_r) begin
						d.sh = {q.sh[6:0], s_lvl[0]};
						d.bc = q.bc + 1'b1;
					end else if (scl_f && q.bc == ACK_SLOT) begin
						d.sda_oe_n = 1'b0;
						d.st = ST_RACK;
						if (q.bi != 2'h3) begin
							d.bi = q.bi + 1'b1;
						end
						case (q.bi)
							2'h0: d.ptr = q.sh;
							2'h1: d.wmsb = q.sh;
							2'h2: begin
								case (q.ptr)
									PTR_CFG: begin
										d.cfg = {q.wmsb, q.sh};
										d.cfg[CFG_STAT] = q.cfg[CFG_STAT];
										d.cfg[CFG_CLR] = 1'b0;
										ev_clr = q.sh[CFG_CLR];
									end
									PTR_UPPER: if (!q.cfg[CFG_WLCK])
										d.upper = {q.wmsb, q.sh};
									PTR_LOWER: if (!q.cfg[CFG_WLCK])
										d.lower = {q.wmsb, q.sh};
									PTR_CRIT: if (!q.cfg[CFG_CLCK])
										d.crit = {q.wmsb, q.sh};
									PTR_BUSC: d.busc = {q.wmsb, q.sh};
									default: ;
								endcase
							end
							default: ;
						endcase
					end
				end
				ST_RACK: begin
					if (scl_f) begin
						d.sda_oe_n = 1'b1;
						d.bc = '0;
						d.st = ST_RX;
					end
				end
				ST_TX: begin
					if (scl_r) begin
						d.bc = q.bc + 1'b1;
						// A released one read back low means a lost race.
						if (q.ara && q.sda_oe_n && !s_lvl[0]) begin
							d.st = ST_IDLE;
						end
					end else if (scl_f) begin
						if (q.bc == ACK_SLOT) begin
							d.sda_oe_n = 1'b1;
							d.st = ST_TACK;
							ev_clr = q.ara;
						end else begin
							d.sh = {q.sh[6:0], 1'b0};
							d.sda_oe_n = q.sh[6];
						end
					end
				end
				ST_TACK: begin
					if (scl_r) begin
						d.nack = s_lvl[0];
					end else if (scl_f) begin
						if (q.nack || q.ara) begin
							d.st = ST_IDLE;
						end else begin
							d.tb = ~q.tb;
							d.sh = q.tb ? q.rdat[15:8] : q.rdat[7:0];
							d.sda_oe_n = q.tb ? q.rdat[15] : q.rdat[7];
							d.bc = '0;
							d.st = ST_TX;
						end
					end
				end
				default: d.st = ST_IDLE;
			endcase
		end

		// Crossing capture; a new crossing beats a same-cycle clear.
		d.alarm_p = above | below | crit_f;
		if (ev_clr) begin
			d.ev = 1'b0;
		end
		if ((above | below | crit_f) != q.alarm_p) begin
			d.ev = 1'b1;
		end
		d.cfg[CFG_STAT] = asserted;
		d.evt_oe_n = ~(q.cfg[CFG_EN] & (asserted ^ q.cfg[CFG_POL]));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign conv_start       = q.conv_start;
	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe_n = q.sda_oe_n;
	assign bus.dev_evt_o    = 1'b0;
	assign bus.dev_evt_oe_n = q.evt_oe_n;
endmodule : tss_dev

/* File: hdl/tss_host.sv */
`timescale 1ns/10ps
module tss_host
	import tss_pkg::*;
#(
	parameter int QTR_P = tss_pkg::QTR_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	tss_if.host              bus,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata
);
	import tss_pkg::*;

	localparam int DW = $clog2(QTR_P + 1);

	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tss_hst_t;
	typedef enum logic [2:0] {
		OP_AW, OP_AR, OP_P, OP_M, OP_L, OP_RS, OP_RX, OP_END
	} tss_hop_t;

	typedef struct packed {
		tss_hst_t    st;
		logic [1:0]  qa;
		logic [DW-1:0] dcnt;
		logic [3:0]  step;
		logic [3:0]  bc;
		logic [7:0]  sh;
		logic [10:0] cmd;
		logic [6:0]  sadr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic        busy;
		logic        nack;
		logic        scl_oe_n;
		logic        sda_oe_n;
		logic [31:0] rd_q;
	} tss_host_state_t;

	tss_host_state_t q;
	tss_host_state_t d;
	logic [1:0]      s_lvl;
	logic            tick;
	logic            enter;
	logic [3:0]      ns;

	// Program of byte steps: write at 0, read with pointer at 5,
	// read at the latched pointer at 8.
	function automatic tss_hop_t op(input logic [3:0] s);
		case (s)
			4'h0, 4'h5: op = OP_AW;
			4'h1, 4'h6: op = OP_P;
			4'h2:       op = OP_M;
			4'h3:       op = OP_L;
			4'h7:       op = OP_RS;
			4'h8:       op = OP_AR;
			4'h9, 4'hA: op = OP_RX;
			default:    op = OP_END;
		endcase
	endfunction : op

	// ==========================================================
	// Pin sampling
	// ==========================================================
	tss_sync #(.W(2)) u_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.din  ({bus.evt, bus.sda}),
		.lvl  (s_lvl),
		.prv  ()
	);

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		d = q;
		enter = 1'b0;
		ns = q.step;
		// Quarter-period enable; 100 kHz keeps well above 10 kHz.
		tick = (q.dcnt == DW'(QTR_P - 1));
		d.dcnt = (tick || q.st == H_IDLE) ? '0 : q.dcnt + 1'b1;
		if (tick) begin
			d.qa = q.qa + 1'b1;
		end

		// Register port; read data stand one cycle later.
		if (reg_rd) begin
			case (reg_addr)
				HR_CMD:   d.rd_q = {21'h0, q.cmd};
				HR_WDATA: d.rd_q = {16'h0, q.wdata};
				HR_STAT:  d.rd_q = {29'h0, s_lvl[1], q.nack, q.busy};
				HR_RDATA: d.rd_q = {16'h0, q.rdata};
				HR_SADR:  d.rd_q = {25'h0, q.sadr};
				default:  d.rd_q = '0;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				HR_WDATA: d.wdata = reg_wdata[15:0];
				HR_SADR:  d.sadr = reg_wdata[6:0];
				HR_CMD: if (!q.busy) begin
					d.cmd = reg_wdata[10:0];
					d.busy = 1'b1;
					d.nack = 1'b0;
					d.qa = '0;
					d.st = H_START;
					d.step = !reg_wdata[CMD_RD] ? 4'h0
						: reg_wdata[CMD_SETP] ? 4'h5 : 4'h8;
				end
				default: ;
			endcase
		end

		if (tick) begin
			case (q.st)
				H_START: begin
					case (q.qa)
						2'h0: d.sda_oe_n = 1'b1;
						2'h1: d.scl_oe_n = 1'b1;
						2'h2: d.sda_oe_n = 1'b0;
						default: begin
							d.scl_oe_n = 1'b0;
							enter = 1'b1;
							ns = (op(q.step) == OP_RS) ? q.step + 1'b1 : q.step;
						end
					endcase
				end
				H_BIT: begin
					case (q.qa)
						2'h0: begin
							if (q.bc != ACK_SLOT) begin
								d.sda_oe_n = (op(q.step) == OP_RX) | q.sh[7];
							end else begin
								// Last read byte gets a not-acknowledge.
								d.sda_oe_n = (op(q.step) != OP_RX)
									| (q.step == 4'hA);
							end
						end
						2'h1: d.scl_oe_n = 1'b1;
						2'h2: if (q.bc != ACK_SLOT)
							d.sh = {q.sh[6:0], s_lvl[0]};
						default: begin
							d.scl_oe_n = 1'b0;
							d.bc = q.bc + 1'b1;
							if (q.bc == ACK_SLOT) begin
								if (q.step == 4'h9) d.rdata[15:8] = q.sh;
								if (q.step == 4'hA) d.rdata[7:0] = q.sh;
								if (op(q.step) != OP_RX && s_lvl[0]) begin
									d.nack = 1'b1;
									d.st = H_STOP;
								end else begin
									enter = 1'b1;
									ns = (q.step == 4'h1 && !q.cmd[CMD_DATA])
										? 4'h4 : q.step + 1'b1;
								end
							end
						end
					endcase
				end
				H_STOP: begin
					case (q.qa)
						2'h0: d.sda_oe_n = 1'b0;
						2'h1: d.scl_oe_n = 1'b1;
						2'h2: d.sda_oe_n = 1'b1;
						default: begin
							d.st = H_IDLE;
							d.busy = 1'b0;
						end
					endcase
				end
				default: ;
			endcase
		end

		// Load the next step of the program.
		if (enter) begin
			d.step = ns;
			d.bc = '0;
			case (op(ns))
				OP_END: d.st = H_STOP;
				OP_RS:  d.st = H_START;
				default: d.st = H_BIT;
			endcase
			case (op(ns))
				OP_AW:   d.sh = {q.sadr, 1'b0};
				OP_AR:   d.sh = {q.sadr, 1'b1};
				OP_P:    d.sh = q.cmd[7:0];
				OP_M:    d.sh = q.wdata[15:8];
				OP_L:    d.sh = q.wdata[7:0];
				default: d.sh = 8'hFF;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{st: H_IDLE, sadr: SADR_RST, scl_oe_n: 1'b1,
				sda_oe_n: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign reg_rdata         = q.rd_q;
	assign bus.host_scl_o    = 1'b0;
	assign bus.host_scl_oe_n = q.scl_oe_n;
	assign bus.host_sda_o    = 1'b0;
	assign bus.host_sda_oe_n = q.sda_oe_n;
endmodule : tss_host

/* File: hdl/tss_if.sv */
`timescale 1ns/10ps
interface tss_if;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic dev_evt_o;
	logic dev_evt_oe_n;
	logic scl;
	logic sda;
	logic evt;

	// Pulled-up open-drain wires: released means high.
	assign scl = host_scl_oe_n | host_scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
	assign evt = dev_evt_oe_n | dev_evt_o;

	modport dev (input scl, sda, output dev_sda_o, dev_sda_oe_n,
		dev_evt_o, dev_evt_oe_n);
	modport host (input scl, sda, evt, output host_scl_o, host_scl_oe_n,
		host_sda_o, host_sda_oe_n);
endinterface : tss_if

/* File: hdl/tss_pkg.sv */
package tss_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam longint CLK_HZ      = 64'd125000000;
	localparam longint CONV_MS     = 64'd125;
	localparam longint TOUT_MIN_MS = 64'd25;
	localparam longint TOUT_MAX_MS = 64'd35;
	localparam longint SCL_KHZ     = 64'd100;
	// Longest time rounds down, least time rounds up.
	localparam int CONV_CYC = int'(CONV_MS * CLK_HZ / 64'd1000);
	localparam int TOUT_CYC = int'((TOUT_MIN_MS * CLK_HZ + 64'd999) / 64'd1000);
	localparam int QTR_CYC  = int'(CLK_HZ / (SCL_KHZ * 64'd4000));

	// ==========================================================
	// Sensor register map
	// ==========================================================
	localparam logic [7:0]  PTR_CAP   = 8'h00;
	localparam logic [7:0]  PTR_CFG   = 8'h01;
	localparam logic [7:0]  PTR_UPPER = 8'h02;
	localparam logic [7:0]  PTR_LOWER = 8'h03;
	localparam logic [7:0]  PTR_CRIT  = 8'h04;
	localparam logic [7:0]  PTR_TEMP  = 8'h05;
	localparam logic [7:0]  PTR_BUSC  = 8'h22;
	localparam logic [7:0]  PTR_RST   = 8'h00;
	localparam logic [15:0] CAP_RST   = 16'h00F7;
	localparam logic [15:0] CFG_RST   = 16'h0000;
	localparam logic [15:0] LIM_RST   = 16'h0000;
	localparam logic [15:0] BUSC_RST  = 16'h0021;
	localparam int CFG_MODE = 0;
	localparam int CFG_POL  = 1;
	localparam int CFG_EN   = 3;
	localparam int CFG_STAT = 4;
	localparam int CFG_CLR  = 5;
	localparam int CFG_WLCK = 6;
	localparam int CFG_CLCK = 7;
	localparam int BUSC_ARA_OFF  = 0;
	localparam int BUSC_TOUT_OFF = 7;
	localparam int TEMP_W        = 13;

	// ==========================================================
	// Link constants
	// ==========================================================
	localparam logic [3:0] TS_TYPE   = 4'h3;
	localparam logic [6:0] ARA_ADDR  = 7'h0C;
	localparam logic [3:0] ACK_SLOT  = 4'h8;

	// ==========================================================
	// Host command registers
	// ==========================================================
	localparam logic [7:0] HR_CMD   = 8'h00;
	localparam logic [7:0] HR_WDATA = 8'h04;
	localparam logic [7:0] HR_STAT  = 8'h08;
	localparam logic [7:0] HR_RDATA = 8'h0C;
	localparam logic [7:0] HR_SADR  = 8'h10;
	localparam int CMD_RD   = 8;
	localparam int CMD_SETP = 9;
	localparam int CMD_DATA = 10;
	localparam logic [6:0] SADR_RST = 7'h18;

endpackage : tss_pkg

/* File: hdl/tss_sync.sv */
`timescale 1ns/10ps
module tss_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] prv
);
	typedef struct packed {
		logic [W-1:0] m;
		logic [W-1:0] s;
		logic [W-1:0] p;
	} tss_sync_t;

	tss_sync_t q;
	tss_sync_t d;

	// ==========================================================
	// Two-stage synchroniser plus one stage for edge finding
	// ==========================================================
	// Only the second stage reads the first.
	always_comb begin
		d.m = din;
		d.s = q.m;
		d.p = q.s;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign lvl = q.s;
	assign prv = q.p;
endmodule : tss_sync

/* File: testbench/temp_sensor_smbus_slave_tb.sv */
`timescale 1ns/10ps
// ==========
// Bench top
module temp_sensor_smbus_slave_tb;
	import tss_pkg::*;
	localparam int CONV_T = 200;
	localparam logic [7:0] PT [6] = '{PTR_CAP, PTR_CFG, PTR_UPPER,
		PTR_LOWER, PTR_CRIT, PTR_BUSC};
	// Status is live: a zero temperature already meets the zero critical limit.
	localparam logic [15:0] EX [6] = '{CAP_RST,
		CFG_RST | (16'h1 << CFG_STAT), LIM_RST, LIM_RST, LIM_RST, BUSC_RST};
	localparam logic [15:0] WV [5] = '{CAP_RST, CFG_RST, 16'h0550,
		16'h1F40, 16'h05F0};
	logic              clk;
	logic              rst_n;
	logic [7:0]        reg_addr;
	logic [31:0]       reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [31:0]       reg_rdata;
	logic [TEMP_W-1:0] conv_data;
	logic              conv_valid;
	logic              conv_start;
	logic [31:0]       d;
	int                n_fail;
	int                n_compared;
	int                k;

	tss_if bus ();
	tss_dev #(.CONV_P(CONV_T), .TOUT_P(2000)) tss_dev_i (
		.clk(clk), .rst_n(rst_n), .bus(bus.dev), .addr_pins(3'h0),
		.conv_data(conv_data), .conv_valid(conv_valid),
		.conv_start(conv_start));
	tss_host #(.QTR_P(8)) tss_host_i (
		.clk(clk), .rst_n(rst_n), .bus(bus.host), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	tss_checker #(.TOUT_P(2000)) tss_checker_i (
		.clk(clk), .rst_n(rst_n), .host_scl_o(bus.host_scl_o),
		.host_scl_oe_n(bus.host_scl_oe_n),
		.host_sda_oe_n(bus.host_sda_oe_n), .dev_sda_o(bus.dev_sda_o),
		.dev_sda_oe_n(bus.dev_sda_oe_n), .dev_evt_o(bus.dev_evt_o),
		.dev_evt_oe_n(bus.dev_evt_oe_n), .scl(bus.scl));

	// ==========
	// Tasks
	task automatic complete_run;
		$display("Compared %0d, mismatches %0d.", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand from the cycle after the strobe until the next read.
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd

	// Starts one link transfer and polls busy under a bound.
	task automatic xfer(input logic [31:0] c);
		int i;
		wr(HR_CMD, c);
		for (i = 0; i < 2000; i++) begin
			rd(HR_STAT);
			if (d[0] === 1'b0) break;
		end
		if (i == 2000) begin
			n_fail++;
			$display("[FAIL] %0t: transfer never ended", $time);
			complete_run();
		end
	endtask : xfer

	task automatic rreg(input logic [7:0] p, input logic [15:0] e);
		xfer(32'(p) | (32'h1 << CMD_RD) | (32'h1 << CMD_SETP));
		rd(HR_RDATA);
		chk(d, 32'(e));
	endtask : rreg

	task automatic wreg(input logic [7:0] p, input logic [15:0] v);
		wr(HR_WDATA, 32'(v));
		xfer(32'(p) | (32'h1 << CMD_DATA));
	endtask : wreg

	task automatic temp(input logic [TEMP_W-1:0] t);
		@(posedge clk);
		conv_data <= t;
		conv_valid <= 1'b1;
		@(posedge clk);
		conv_valid <= 1'b0;
		// Let a crossing reach the event pin before anyone looks at it.
		repeat (3) @(negedge clk);
	endtask : temp

	// Alert answer attempt; e is the expected not-acknowledge flag.
	task automatic ara(input logic e);
		wr(HR_SADR, 32'(ARA_ADDR));
		xfer(32'h1 << CMD_RD);
		rd(HR_STAT);
		chk(32'(d[1]), 32'(e));
		wr(HR_SADR, 32'(SADR_RST));
	endtask : ara

	// ==========
	// Clock and sequence
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Tests run in order; each leaves the sensor state the next one needs.
	initial begin
		{rst_n, reg_wr, reg_rd, conv_valid} = 4'h0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		conv_data = '0;
		n_fail = 0;
		n_compared = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		chk(32'(bus.evt), 32'h1);
		xfer(32'h1 << CMD_RD);
		rd(HR_RDATA);
		chk(d, 32'(CAP_RST));
		for (k = 0; k < 6; k++) rreg(PT[k], EX[k]);
		rd(8'h20);
		chk(d, 32'h0);
		$display("Reset test done.");
		wreg(PTR_UPPER, 16'h0550);
		wreg(PTR_LOWER, 16'h1F40);
		wreg(PTR_CRIT, 16'h05F0);
		wreg(PTR_CAP, 16'h1234);
		for (k = 0; k < 5; k++) rreg(PT[k], WV[k]);
		xfer(32'h1 << CMD_RD);
		rd(HR_RDATA);
		chk(d, 32'h05F0);
		$display("Register test done.");
		temp(13'h0190);
		rreg(PTR_TEMP, 16'h0190);
		fork
			rreg(PTR_TEMP, 16'h0190);
			begin
				repeat (1200) @(posedge clk);
				temp(13'h0200);
			end
		join
		rreg(PTR_TEMP, 16'h0200);
		for (k = 0; k < 400 && conv_start !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
		for (k = 1; k < 400 && conv_start !== 1'b1; k++) @(negedge clk);
		chk(32'(k), 32'(CONV_T));
		$display("Temperature test done.");
		wreg(PTR_CFG, 16'h0008);
		temp(13'h0560);
		rreg(PTR_TEMP, 16'h4560);
		chk(32'(bus.evt), 32'h0);
		rreg(PTR_CFG, 16'h0018);
		wreg(PTR_CFG, 16'h000A);
		chk(32'(bus.evt), 32'h1);
		wreg(PTR_BUSC, 16'h0020);
		rreg(PTR_BUSC, 16'h0020);
		ara(1'b1);
		// Interrupt mode with a clear, so the pin waits for a real crossing.
		wreg(PTR_CFG, 16'h0029);
		chk(32'(bus.evt), 32'h1);
		rreg(PTR_CFG, 16'h0009);
		temp(13'h0100);
		temp(13'h0560);
		chk(32'(bus.evt), 32'h0);
		wreg(PTR_BUSC, BUSC_RST);
		ara(1'b1);
		wreg(PTR_BUSC, 16'h0020);
		ara(1'b0);
		chk(32'(bus.evt), 32'h1);
		$display("Event test done.");
		complete_run();
	end
endmodule : temp_sensor_smbus_slave_tb

/* File: testbench/tss_checker.sv */
`timescale 1ns/10ps
// ==========
// Link checker
module tss_checker #(
	parameter int TOUT_P = 2000
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic host_scl_o,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic dev_evt_o,
	input wire logic dev_evt_oe_n,
	input wire logic scl
);
	logic [15:0] low_q;

	// Counts SCL low cycles, so a stalled host shows up long before a hang.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_q <= 16'h0;
		end else begin
			low_q <= scl ? 16'h0 : low_q + 16'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_sda_pull_only: assert property (!dev_sda_o)
		else $error("Device drove SDA high.");
	a_evt_pull_only: assert property (!dev_evt_o)
		else $error("Event pin driven high.");
	a_scl_host_only: assert property (
		scl == (host_scl_oe_n | host_scl_o))
		else $error("SCL level not set by host alone.");
	a_sda_moves_low: assert property (
		$changed(dev_sda_oe_n) |-> !scl)
		else $error("Device moved SDA while SCL high.");
	a_no_sda_clash: assert property (
		scl && !dev_sda_oe_n |-> host_sda_oe_n)
		else $error("Both ends drove SDA in one bit.");
	a_start_dev_free: assert property (
		$fell(host_sda_oe_n) && scl |-> dev_sda_oe_n)
		else $error("Device held SDA at a start.");
	a_evt_off_reset: assert property (
		$rose(rst_n) |-> dev_evt_oe_n [*8])
		else $error("Event pin active after reset.");
	a_host_clock_rate: assert property (low_q < TOUT_P)
		else $error("Host held SCL low too long.");

	c_dev_ack: cover property ($fell(dev_sda_oe_n));
	c_evt_low: cover property (!dev_evt_oe_n);
	c_start: cover property ($fell(host_sda_oe_n) && scl);
endmodule : tss_checker
